//--- rtl/pulse_measure_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "pulse_measure_consts.svh"

// What this block does
// - Bit 7 picks module or alternative clock
// - Bits 6-5 route one of four inputs
// - Mode 00: fall trigger, capture falls
// - Mode 01: rise trigger, capture both edges
// - Mode 10: fall trigger, capture both edges
// - Mode 11: rise trigger, capture rises
// - Three-bit code divides clock by 1..128
// - Control byte at index 1, resets zero
// - Positive width high byte at index 2
// - Trigger clears counter; capture copies, restarts
// - Falling captures positive, rising captures negative
module pulse_measure_timer
    import pulse_measure_pkg::*;
#(
    parameter int WIDTH_BITS = 16
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Measured party
    input  wire logic [3:0]  measured_input,
    input  wire logic        alt_clock,
    // AXI4-Lite write address
    input  wire logic [5:0]  awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    // AXI4-Lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    // AXI4-Lite write response
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    // AXI4-Lite read address
    input  wire logic [5:0]  araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    // AXI4-Lite read data
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0]              control_r;      // Measure control byte
    logic                    module_on_r;    // Counter enable
    logic                    restart_r;      // One-cycle soft restart pulse
    logic                    valid_r;        // Width valid flag
    logic [WIDTH_BITS-1:0]   counter_r;      // Measurement counter
    logic [6:0]              prescale_r;     // Prescaler count
    logic [WIDTH_BITS-1:0]   pos_width_r;    // Captured positive width
    logic [WIDTH_BITS-1:0]   neg_width_r;    // Captured negative width
    logic                    sample_r;       // Selected input, registered
    logic                    sample_old_r;   // Previous sample
    logic                    alt_r;          // Registered alternative clock
    logic                    alt_old_r;      // Previous alternative clock
    measure_state_type       state_r;        // Sequencer state
    measure_state_type       state_nxt;
    logic                    awready_r;      // Write address taken pulse
    logic                    wready_r;       // Write data taken pulse
    logic                    bvalid_r;       // Write answer pending
    logic                    arready_r;      // Read address taken pulse
    logic                    rvalid_r;       // Read answer pending
    logic [1:0]              bresp_r;        // Write answer code
    logic [1:0]              rresp_r;        // Read answer code
    logic [31:0]             rdata_r;        // Read answer word

    ////////////////////////////////////////////////////////////////////////////
    // Field decode

    // Fields act straight from the control byte. Changing the edge mode
    // while running leaves the sequencer in whatever state it was in, so
    // software is expected to restart the module after a mode change.
    // Input select and divider take effect on the next cycle; a change
    // of input select while measuring may itself look like an edge.
    wire [1:0] edge_mode  = control_r[`EDGE_MODE_HI:`EDGE_MODE_LO];
    wire [1:0] input_sel  = control_r[`INPUT_SELECT_HI:`INPUT_SELECT_LO];
    wire [2:0] divider    = control_r[`DIVIDER_HI:`DIVIDER_LO];
    wire       use_alt    = control_r[`CLOCK_SOURCE_BIT];

    // Chosen input
    // Unselected lanes are ignored entirely; only the picked lane reaches
    // the two sampling flops. Edges are found one cycle after the first
    // flop, so a level must stand at least one clock to be seen at all.
    wire       input_pick = measured_input[input_sel];
    wire       rise       = sample_r & ~sample_old_r;
    wire       fall       = ~sample_r & sample_old_r;

    // Trigger on rising edge for modes 01 and 11, else falling
    // The trigger edge only arms the sequencer and zeroes the counter and prescaler.
    // Every qualifying edge after it is a capture edge. Only one of
    // rise and fall can be true in a cycle, so a capture always lands
    // in exactly one of the two width registers.
    wire       trig_rise  = edge_mode[0];
    wire       trig_edge  = trig_rise ? rise : fall;
    // Falling captures in modes 00, 01, 10; rising in 01, 10, 11
    wire       cap_fall   = fall & (edge_mode != `EDGE_RISE_RISE);
    wire       cap_rise   = rise & (edge_mode != `EDGE_FALL_FALL);
    wire       capture    = (state_r == MEASURING) & (cap_fall | cap_rise);
    wire       trigger    = (state_r == WAIT_TRIGGER) & trig_edge;
    wire       restart    = restart_r | ~module_on_r;

    // Source tick: every cycle on module clock, alt rising edge otherwise
    // The alternative clock is sampled by the bus clock, so it must run
    // at no more than half the bus rate or rising edges will be lost. Its edge
    // is found on registered copies, which costs one cycle of latency
    // but keeps the tick a single clean cycle wide.
    wire       src_tick   = use_alt ? (alt_r & ~alt_old_r) : 1'b1;
    // Prescaler wraps at 2**divider - 1
    wire [6:0] pre_mask   = 7'(({7'h00, 1'b1} << divider) - 8'h01);
    wire       div_tick   = src_tick & ((prescale_r & pre_mask) == pre_mask);

    // Register bus decode
    // A write is taken only when address and data are both offered and
    // no earlier answer is still pending; the master may offer them in
    // any order and the slave simply waits for the pair. Reads are
    // independent of writes and may overlap them. Only byte lane 0
    // carries register data; a write with that strobe low changes nothing.
    wire       wr_go      = awvalid & wvalid & ~awready_r & ~bvalid_r;
    wire       rd_go      = arvalid & ~arready_r & ~rvalid_r;
    wire       wr_run     = wr_go & (awaddr == `RUN_CONTROL_ADDR) & wstrb[0];
    wire       wr_ctrl    = wr_go & (awaddr == `MEASURE_CONTROL_ADDR) & wstrb[0];
    wire       wr_hit     = (awaddr == `RUN_CONTROL_ADDR) | (awaddr == `MEASURE_CONTROL_ADDR);
    wire       valid_clr  = wr_run & valid_r & ~wdata[`WIDTH_VALID_BIT];
    wire [7:0] run_view   = {module_on_r, 5'h00, valid_r, 1'b0};
    wire [7:0] rd_byte;
    wire       rd_hit;

    // Read mux; soft restart always reads zero
    // Width registers show only their high byte here. Unmapped places
    // read as zero and are answered with an error code.
    assign rd_hit  = (araddr == `RUN_CONTROL_ADDR) | (araddr == `MEASURE_CONTROL_ADDR) |
                     (araddr == `POS_WIDTH_HIGH_ADDR) | (araddr == `NEG_WIDTH_HIGH_ADDR);
    assign rd_byte = (araddr == `RUN_CONTROL_ADDR)     ? run_view :
                     (araddr == `MEASURE_CONTROL_ADDR) ? control_r :
                     (araddr == `POS_WIDTH_HIGH_ADDR)  ? pos_width_r[15:8] :
                     (araddr == `NEG_WIDTH_HIGH_ADDR)  ? neg_width_r[15:8] : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    // Measure control byte, all zero after reset
    // Every field is plain read and write, so software gets back exactly
    // what it last wrote.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_r <= `MEASURE_CONTROL_RESET;
        end else if (wr_ctrl) begin
            control_r <= wdata[7:0];
        end
    end

    // Run control: enable, restart pulse, valid flag (set wins over clear)
    // The restart bit is never stored: it becomes a one-cycle pulse and
    // reads back as zero. Letting a capture beat a clear in the same cycle
    // means software can never lose notice of a fresh width. Turning the
    // module off holds the whole measurement path in restart.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            module_on_r <= 1'b0;
            restart_r   <= 1'b0;
            valid_r     <= 1'b0;
        end else begin
            if (wr_run) begin
                module_on_r <= wdata[`MODULE_ON_BIT];
            end
            restart_r <= wr_run & wdata[`SOFT_RESTART_BIT];
            if (capture) begin
                valid_r <= 1'b1;
            end else if (valid_clr | restart) begin
                valid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input sampling

    // Register selected input and alternative clock for edge finding
    // Both inputs are taken as synchronous to the bus clock; the flops
    // here find edges and are not meant as metastability guards.
    // Sample flops reset low to match the idle level of the lanes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_r     <= 1'b0;
            sample_old_r <= 1'b0;
            alt_r        <= 1'b0;
            alt_old_r    <= 1'b0;
        end else begin
            sample_r     <= input_pick;
            sample_old_r <= sample_r;
            alt_r        <= alt_clock;
            alt_old_r    <= alt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    // Restart sends the sequencer back to await the trigger edge
    // Once measuring, the sequencer stays there until restart; every
    // later qualifying edge is a capture, never a new trigger.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            WAIT_TRIGGER: begin
                if (trigger) begin
                    state_nxt = MEASURING;
                end
            end
            MEASURING: begin
                state_nxt = MEASURING;
            end
            default: begin
                state_nxt = WAIT_TRIGGER;
            end
        endcase
        if (restart) begin
            state_nxt = WAIT_TRIGGER;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= WAIT_TRIGGER;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter and prescaler

    // Trigger and capture both zero counter and prescaler
    // The counter is free running and simply wraps if no edge comes for
    // a long time; no overflow is reported by this block. Zeroing the
    // prescaler too means every width starts on a whole divided tick.
    // The counter holds while the chosen source gives no tick.
    always_ff @(posedge aclk) begin
        if (!aresetn || restart || trigger || capture) begin
            counter_r  <= `WIDTH_RESET;
            prescale_r <= 7'h00;
        end else begin
            if (src_tick) begin
                prescale_r <= div_tick ? 7'h00 : prescale_r + 7'h01;
            end
            if (div_tick) begin
                counter_r <= counter_r + 1'b1;
            end
        end
    end

    // Falling captures are positive width, rising are negative
    // The counter value taken is that of the capture cycle, before it
    // is zeroed; widths keep their value across restarts.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos_width_r <= `WIDTH_RESET;
            neg_width_r <= `WIDTH_RESET;
        end else if (capture) begin
            if (cap_fall) begin
                pos_width_r <= counter_r;
            end else begin
                neg_width_r <= counter_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    // Write: take address and data together, answer one cycle later
    // The ready pulses and the answer rise on the same edge; the answer
    // then stands until the master accepts it, and no new write is taken
    // while it stands.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `RESP_OKAY;
        end else begin
            awready_r <= wr_go;
            wready_r  <= wr_go;
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read: latch data with the address handshake
    // Data are frozen when the read is taken, so the word stays steady
    // however long the master waits to accept it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `RESP_OKAY;
        end else begin
            arready_r <= rd_go;
            if (rd_go) begin
                rvalid_r <= 1'b1;
                rdata_r  <= {24'h000000, rd_byte};
                rresp_r  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign awready = awready_r;
    assign wready  = wready_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign arready = arready_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;

endmodule : pulse_measure_timer

`default_nettype wire

//--- rtl/pulse_measure_consts.svh
`ifndef PULSE_MEASURE_CONSTS_SVH
`define PULSE_MEASURE_CONSTS_SVH

// Register indices; byte address is four times the index
`define RUN_CONTROL_INDEX        4'h0
`define MEASURE_CONTROL_INDEX    4'h1
`define POS_WIDTH_HIGH_INDEX     4'h2
`define NEG_WIDTH_HIGH_INDEX     4'h3

// Byte addresses on the register bus
`define RUN_CONTROL_ADDR         6'h00
`define MEASURE_CONTROL_ADDR     6'h04
`define POS_WIDTH_HIGH_ADDR      6'h08
`define NEG_WIDTH_HIGH_ADDR      6'h0C

// Field positions of the measure control register
`define CLOCK_SOURCE_BIT         7
`define INPUT_SELECT_HI          6
`define INPUT_SELECT_LO          5
`define EDGE_MODE_HI             4
`define EDGE_MODE_LO             3
`define DIVIDER_HI               2
`define DIVIDER_LO               0

// Field positions of the run control register
`define MODULE_ON_BIT            7
`define SOFT_RESTART_BIT         3
`define WIDTH_VALID_BIT          1

// Reset values
`define MEASURE_CONTROL_RESET    8'h00
`define WIDTH_RESET              16'h0000

// Edge mode codes
`define EDGE_FALL_FALL           2'h0
`define EDGE_RISE_BOTH           2'h1
`define EDGE_FALL_BOTH           2'h2
`define EDGE_RISE_RISE           2'h3

// Bus answers
`define RESP_OKAY                2'h0
`define RESP_SLVERR              2'h2

`endif

//--- rtl/pulse_measure_pkg.sv
package pulse_measure_pkg;

    // Measurement sequencer: waiting for the trigger edge, then capturing
    typedef enum logic [0:0] {
        WAIT_TRIGGER,
        MEASURING
    } measure_state_type;

endpackage : pulse_measure_pkg

//--- dv/pulse_measure_timer_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "pulse_measure_consts.svh"
// Bus-side checks of the pulse timer
module pulse_measure_timer_props #(
    parameter int WIDTH_BITS = 16
) (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Write side
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    // Read side
    input wire logic [5:0]  araddr,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////
    chk_aw_one_cycle: assert property (awready |=> !awready)
        else $error("awready held too long");
    chk_w_with_aw: assert property (awready == wready)
        else $error("wready apart from awready");
    chk_write_answer: assert property ((awvalid && wvalid && !bvalid && !awready) |=> (bvalid && awready))
        else $error("write not answered");
    chk_b_stands: assert property ((bvalid && !bready) |=> (bvalid && $stable(bresp)))
        else $error("write answer dropped");
    chk_read_answer: assert property ((arvalid && !rvalid) |=> (rvalid && arready))
        else $error("read not answered");
    chk_r_stands: assert property ((rvalid && !rready) |=> (rvalid && $stable(rdata)))
        else $error("read data not held");
    chk_byte_wide: assert property (rvalid |-> (rdata[31:8] == 24'h000000))
        else $error("upper read bits set");
    chk_unmapped_err: assert property ((arvalid && !rvalid && araddr[5:4] != 2'h0)
        |=> (rresp == `RESP_SLVERR && rdata == 32'h00000000))
        else $error("unmapped read not refused");
    chk_reset_idle: assert property (disable iff (1'b0) !aresetn |=> !(bvalid || rvalid || awready || arready))
        else $error("bus busy in reset");
    // Main scenarios reached
    cover property (bvalid && bready);
    cover property (rvalid && rready && rdata[7:0] != 8'h00);
    cover property (rvalid && rresp == `RESP_SLVERR);
endmodule : pulse_measure_timer_props
`default_nettype wire

//--- dv/pulse_source.sv
`timescale 1ns/1ps
`default_nettype none
// External pulse party: chosen lane follows the bench, others toggle
module pulse_source (
    // Clock
    input  wire logic       aclk,
    // Lane and level asked by the bench
    input  wire logic [1:0] lane,
    input  wire logic       level,
    // Toward the timer
    output var  logic [3:0] measured_input,
    output var  logic       alt_clock
);
    logic [3:0] noise_r = 4'h0; // Busy unselected lanes expose a wrong route
    logic       alt_r   = 1'b0; // Alternative clock, half the bus rate
    // Free-running activity
    always_ff @(posedge aclk) begin
        noise_r <= noise_r + 4'h1;
        alt_r   <= ~alt_r;
    end
    // Selected lane carries the measured level
    always_comb begin
        measured_input       = noise_r;
        measured_input[lane] = level;
        alt_clock            = alt_r;
    end
endmodule : pulse_source
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pulse_measure_consts.svh"
module tb import pulse_measure_pkg::*;;
    localparam int HI_CNT = 400; // High phase in counter ticks
    localparam int LO_CNT = 700; // Low phase in counter ticks
    logic aclk = 1'b0, aresetn = 1'b0, level = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [1:0] lane = 2'h0, bresp, rresp, resp;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [3:0] wstrb = 4'hF, measured_input;
    logic [31:0] wdata = 32'h0, rdata, rd, val;
    logic awready, wready, bvalid, arready, rvalid, alt_clock;
    int errors = 0, n_checks = 0, sh;
    always #4 aclk = ~aclk;
    pulse_measure_timer pulse_measure_timer_i (
        .aclk(aclk), .aresetn(aresetn), .measured_input(measured_input), .alt_clock(alt_clock),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );
    pulse_source pulse_source_i (
        .aclk(aclk), .lane(lane), .level(level), .measured_input(measured_input), .alt_clock(alt_clock)
    );
    ////////////////////////////////////////////////////////////////
    // Compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Register write, waits for the answer
    task automatic axw(input logic [5:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) begin
                awvalid <= 1'b0; wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1);
        resp = bresp; bready <= 1'b0;
    endtask : axw
    // Register read, waits for the answer
    task automatic axr(input logic [5:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata; resp = rresp; rready <= 1'b0;
    endtask : axr
    // Three high/low periods, phases scaled to the tick rate
    task automatic pulses(input int s);
        repeat (3) begin
            level <= 1'b1; repeat (HI_CNT << s) @(posedge aclk);
            level <= 1'b0; repeat (LO_CNT << s) @(posedge aclk);
        end
    endtask : pulses
    // Expected high bytes after running mode m (widths held across modes)
    function automatic logic [31:0] exp_pos(input int m);
        exp_pos = (m == 0) ? 32'((HI_CNT + LO_CNT) >> 8) : 32'(HI_CNT >> 8);
    endfunction : exp_pos
    function automatic logic [31:0] exp_neg(input int m);
        exp_neg = (m == 0) ? 32'h0 : (m == 3) ? 32'((HI_CNT + LO_CNT) >> 8) : 32'(LO_CNT >> 8);
    endfunction : exp_neg
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////
    // Watchdog cuts a hang short
    initial begin
        repeat (45000) @(posedge aclk);
        errors++;
        final_report();
    end
    // Main sequence
    initial begin
        void'($urandom(50802));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axr(`MEASURE_CONTROL_ADDR); chk("control reset", 32'h0, rd);
        chk("read resp", 32'(`RESP_OKAY), 32'(resp));
        axr(`POS_WIDTH_HIGH_ADDR); chk("width reset", 32'h0, rd);
        // Random control values read back
        repeat (6) begin
            val = 32'($urandom) & 32'hFF;
            axw(`MEASURE_CONTROL_ADDR, val); chk("write resp", 32'(`RESP_OKAY), 32'(resp));
            axr(`MEASURE_CONTROL_ADDR); chk("control readback", val, rd);
        end
        // Unmapped places refused
        axw(6'h10, 32'h5A); chk("unmapped write", 32'(`RESP_SLVERR), 32'(resp));
        axr(6'h14); chk("unmapped read", 32'(`RESP_SLVERR), 32'(resp));
        // Mode m on lane m; odd modes tick on the alternative clock
        for (int m = 0; m < 4; m++) begin
            sh = m[0] + m[1];
            val = 32'({m[0], m[1:0], m[1:0], 2'b00, m[1]});
            axw(`RUN_CONTROL_ADDR, 32'h00);
            lane <= 2'(m);
            axw(`MEASURE_CONTROL_ADDR, val);
            axw(`RUN_CONTROL_ADDR, 32'h80);
            @(posedge aclk);
            pulses(sh);
            repeat (8) @(posedge aclk);
            axr(`POS_WIDTH_HIGH_ADDR); chk("positive width", exp_pos(m), rd);
            axr(`NEG_WIDTH_HIGH_ADDR); chk("negative width", exp_neg(m), rd);
        end
        // Flag set by captures, soft restart clears it and reads zero
        axr(`RUN_CONTROL_ADDR); chk("run status", 32'h82, rd);
        axw(`RUN_CONTROL_ADDR, 32'h88);
        axr(`RUN_CONTROL_ADDR); chk("run after restart", 32'h80, rd);
        // Write with byte lane 0 off changes nothing
        wstrb <= 4'h0;
        axw(`MEASURE_CONTROL_ADDR, 32'h00);
        wstrb <= 4'hF;
        axr(`MEASURE_CONTROL_ADDR); chk("strobe off keeps", val, rd);
        final_report();
    end
endmodule : tb
bind pulse_measure_timer pulse_measure_timer_props #(.WIDTH_BITS(WIDTH_BITS)) props_i (.*);
`default_nettype wire
